/* hdl/sem_access.sv */
// One semaphore read or write on the device pins, with a recovery gap after it.
// Assumes data_in is synchronous to clk and settles within the access time.
`timescale 1ns/10ps
`default_nettype none
module sem_access #(
    parameter int DW = sem_host_pkg::DATA_W,
    parameter int ACC_CYC = sem_host_pkg::ACCESS_CYC,
    parameter int REC_CYC = sem_host_pkg::RECOVER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    sem_access_if.seq acc,
    input wire logic [DW-1:0] data_in,
    output logic sem_n,
    output logic ce_n,
    output logic oe_n,
    output logic rw_n,
    output logic [sem_host_pkg::IDX_W-1:0] index,
    output logic [DW-1:0] data_out,
    output logic data_oe
);
    typedef enum {AC_IDLE, AC_ACTIVE, AC_RECOVER} acc_state_t;
    acc_state_t state_r;
    logic [sem_host_pkg::CNT_W-1:0] cnt_r;
    logic sem_n_r, oe_n_r, rw_n_r, data_oe_r, done_r, rbit_r;
    logic [sem_host_pkg::IDX_W-1:0] index_r;
    logic [DW-1:0] data_out_r;

    assign sem_n = sem_n_r;
    assign ce_n = 1'h1;
    assign oe_n = oe_n_r;
    assign rw_n = rw_n_r;
    assign index = index_r;
    assign data_out = data_out_r;
    assign data_oe = data_oe_r;
    assign acc.done = done_r;
    assign acc.rbit = rbit_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= AC_IDLE;
            cnt_r <= '0;
            sem_n_r <= 1'h1;
            oe_n_r <= 1'h1;
            rw_n_r <= 1'h1;
            index_r <= sem_host_pkg::IDX_FIRST;
            data_out_r <= '0;
            data_oe_r <= 1'h0;
            done_r <= 1'h0;
            rbit_r <= 1'h0;
        end else begin
            done_r <= 1'h0;
            unique case (state_r)
                AC_IDLE: begin
                    if (acc.start) begin
                        sem_n_r <= 1'h0;
                        rw_n_r <= !acc.is_write;
                        oe_n_r <= acc.is_write;
                        index_r <= acc.index;
                        // Bit zero carries the value; copies on the rest are harmless
                        data_out_r <= {DW{acc.wbit}};
                        data_oe_r <= acc.is_write;
                        cnt_r <= sem_host_pkg::CNT_W'(ACC_CYC - 1);
                        state_r <= AC_ACTIVE;
                    end
                end
                AC_ACTIVE: begin
                    if (cnt_r == '0) begin
                        if (rw_n_r) begin
                            rbit_r <= data_in[0];
                        end
                        // Both strobes drop so the next read latches afresh
                        sem_n_r <= 1'h1;
                        oe_n_r <= 1'h1;
                        rw_n_r <= 1'h1;
                        cnt_r <= sem_host_pkg::CNT_W'(REC_CYC - 1);
                        state_r <= AC_RECOVER;
                    end else begin
                        cnt_r <= cnt_r - sem_host_pkg::CNT_W'(1'h1);
                    end
                end
                AC_RECOVER: begin
                    // Data held one cycle past the write strobe for hold time
                    data_oe_r <= 1'h0;
                    if (cnt_r == '0) begin
                        done_r <= 1'h1;
                        state_r <= AC_IDLE;
                    end else begin
                        cnt_r <= cnt_r - sem_host_pkg::CNT_W'(1'h1);
                    end
                end
            endcase
        end
    end

    property p_ce_high;
        @(posedge clk) disable iff (rst) !sem_n_r |-> ce_n;
    endproperty
    a_ce_high: assert property (p_ce_high) else $error("chip enable low in semaphore access");

    property p_sem_gap;
        @(posedge clk) disable iff (rst) $rose(sem_n_r) |-> sem_n_r [*2];
    endproperty
    a_sem_gap: assert property (p_sem_gap) else $error("select reasserted too soon");

    property p_strobe_in_sem;
        @(posedge clk) disable iff (rst) (!rw_n_r || !oe_n_r) |-> !sem_n_r && (rw_n_r != oe_n_r);
    endproperty
    a_strobe_in_sem: assert property (p_strobe_in_sem) else $error("strobe outside select");

    property p_write_value;
        @(posedge clk) disable iff (rst)
            !rw_n_r |-> data_oe_r && (data_out_r == {DW{data_out_r[0]}});
    endproperty
    a_write_value: assert property (p_write_value) else $error("write data not driven");
endmodule
`default_nettype wire

/* hdl/sem_access_if.sv */
// Request and answer between the command sequencer and the pin cycle engine.
// Assumes both ends share one clock; start is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
interface sem_access_if;
    logic start;
    logic is_write;
    logic [sem_host_pkg::IDX_W-1:0] index;
    logic wbit;
    logic done;
    logic rbit;
    modport ctrl (output start, output is_write, output index, output wbit,
                  input done, input rbit);
    modport seq (input start, input is_write, input index, input wbit,
                 output done, output rbit);
endinterface
`default_nettype wire

/* hdl/sem_host.sv */
// Host controller for one port of a dual-port semaphore bank.
// Assumes the far device follows its own arbitration; pins are synchronous to CLK.
`timescale 1ns/10ps
`default_nettype none
module sem_host #(
    parameter int DW = sem_host_pkg::DATA_W,
    parameter int ACC_CYC = sem_host_pkg::ACCESS_CYC,
    parameter int REC_CYC = sem_host_pkg::RECOVER_CYC
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_OP,
    input wire logic [sem_host_pkg::IDX_W-1:0] CMD_INDEX,
    output logic CMD_READY,
    output logic RESULT_VALID,
    output logic RESULT_GRANTED,
    output logic RESULT_REFUSED,
    output logic INIT_DONE,
    output logic SEMAPHORE_SELECT_N,
    output logic CHIP_ENABLE_N,
    output logic OUTPUT_ENABLE_N,
    output logic READ_WRITE_N,
    output logic [sem_host_pkg::IDX_W-1:0] SEMAPHORE_INDEX,
    output logic [DW-1:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic [DW-1:0] DATA_IN
);
    typedef enum {ST_IDLE, ST_START, ST_WAIT} host_state_t;
    host_state_t state_r;
    sem_host_pkg::op_t op_r, cmd_op;
    logic [sem_host_pkg::IDX_W-1:0] idx_r, pend_idx_r;
    logic step_r, start_r, is_write_r, wbit_r;
    logic cmd_ready_r, res_valid_r, res_granted_r, res_refused_r;
    logic init_done_r, pending_r, claim_wrote_r;
    logic take, legal, fin, granted_nxt;

    sem_access_if acc ();

    assign acc.start = start_r;
    assign acc.is_write = is_write_r;
    assign acc.index = idx_r;
    assign acc.wbit = wbit_r;
    assign CMD_READY = cmd_ready_r;
    assign RESULT_VALID = res_valid_r;
    assign RESULT_GRANTED = res_granted_r;
    assign RESULT_REFUSED = res_refused_r;
    assign INIT_DONE = init_done_r;

    sem_access #(.DW(DW), .ACC_CYC(ACC_CYC), .REC_CYC(REC_CYC)) u_access (
        .clk(CLK),
        .rst(SYS_RST),
        .acc(acc.seq),
        .data_in(DATA_IN),
        .sem_n(SEMAPHORE_SELECT_N),
        .ce_n(CHIP_ENABLE_N),
        .oe_n(OUTPUT_ENABLE_N),
        .rw_n(READ_WRITE_N),
        .index(SEMAPHORE_INDEX),
        .data_out(DATA_OUT),
        .data_oe(DATA_OE)
    );

    always_comb begin
        cmd_op = sem_host_pkg::op_t'(CMD_OP);
        take = CMD_VALID && cmd_ready_r;
        // Init always runs; other ops are refused until init, and with a failed claim open only poll or withdraw of its index
        legal = (cmd_op == sem_host_pkg::OP_INIT) || (init_done_r && (!pending_r ||
                (((cmd_op == sem_host_pkg::OP_POLL) || (cmd_op == sem_host_pkg::OP_RELEASE))
                && (CMD_INDEX == pend_idx_r))));
        fin = (state_r == ST_WAIT) && acc.done
            && !((op_r == sem_host_pkg::OP_INIT) && (idx_r != sem_host_pkg::IDX_LAST))
            && !((op_r == sem_host_pkg::OP_CLAIM) && !step_r);
        // Read back zero means this port holds the token
        granted_nxt = ((op_r == sem_host_pkg::OP_CLAIM) || (op_r == sem_host_pkg::OP_POLL))
            ? (acc.rbit == sem_host_pkg::SEM_REQ) : 1'h1;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_r <= ST_IDLE;
            op_r <= sem_host_pkg::OP_INIT;
            idx_r <= sem_host_pkg::IDX_FIRST;
            step_r <= 1'h0;
            start_r <= 1'h0;
            is_write_r <= 1'h0;
            wbit_r <= sem_host_pkg::SEM_FREE;
            cmd_ready_r <= 1'h0;
        end else begin
            start_r <= 1'h0;
            unique case (state_r)
                ST_IDLE: begin
                    cmd_ready_r <= !take || !legal;
                    if (take && legal) begin
                        op_r <= cmd_op;
                        idx_r <= (cmd_op == sem_host_pkg::OP_INIT) ? sem_host_pkg::IDX_FIRST
                                                                  : CMD_INDEX;
                        step_r <= 1'h0;
                        state_r <= ST_START;
                    end
                end
                ST_START: begin
                    start_r <= 1'h1;
                    // Claim writes its zero before any read of the flag
                    is_write_r <= (op_r == sem_host_pkg::OP_INIT) ||
                                  (op_r == sem_host_pkg::OP_RELEASE) ||
                                  ((op_r == sem_host_pkg::OP_CLAIM) && !step_r);
                    wbit_r <= (op_r == sem_host_pkg::OP_CLAIM) ? sem_host_pkg::SEM_REQ
                                                               : sem_host_pkg::SEM_FREE;
                    state_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (fin) begin
                        cmd_ready_r <= 1'h1;
                        state_r <= ST_IDLE;
                    end else if (acc.done) begin
                        if (op_r == sem_host_pkg::OP_INIT) begin
                            idx_r <= idx_r + sem_host_pkg::IDX_W'(1'h1);
                        end
                        step_r <= 1'h1;
                        state_r <= ST_START;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            res_valid_r <= 1'h0;
            res_granted_r <= 1'h0;
            res_refused_r <= 1'h0;
        end else begin
            res_valid_r <= fin || (take && !legal);
            res_refused_r <= take && !legal;
            res_granted_r <= fin && granted_nxt;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            init_done_r <= 1'h0;
            pending_r <= 1'h0;
            pend_idx_r <= sem_host_pkg::IDX_FIRST;
            claim_wrote_r <= 1'h0;
        end else begin
            if (fin && (op_r == sem_host_pkg::OP_INIT)) begin
                init_done_r <= 1'h1;
            end
            if (state_r == ST_IDLE) begin
                claim_wrote_r <= 1'h0;
            end else if (acc.done && (op_r == sem_host_pkg::OP_CLAIM) && !step_r) begin
                claim_wrote_r <= 1'h1;
            end
            // A failed claim leaves our request latch at zero on the device
            if (fin && (op_r == sem_host_pkg::OP_CLAIM) && !granted_nxt) begin
                pending_r <= 1'h1;
                pend_idx_r <= idx_r;
            end else if (fin && (op_r != sem_host_pkg::OP_CLAIM) && granted_nxt) begin
                pending_r <= 1'h0;
            end
        end
    end

    property p_read_after_write;
        @(posedge CLK) disable iff (SYS_RST)
            (start_r && !is_write_r && (op_r == sem_host_pkg::OP_CLAIM)) |-> claim_wrote_r;
    endproperty
    a_read_after_write: assert property (p_read_after_write) else $error("claim read before write");

    property p_stray_refused;
        @(posedge CLK) disable iff (SYS_RST)
            (take && pending_r && (cmd_op == sem_host_pkg::OP_CLAIM)) |=> res_refused_r && res_valid_r;
    endproperty
    a_stray_refused: assert property (p_stray_refused) else $error("claim taken while pending");

    property p_init_first;
        @(posedge CLK) disable iff (SYS_RST)
            start_r |-> init_done_r || (op_r == sem_host_pkg::OP_INIT);
    endproperty
    a_init_first: assert property (p_init_first) else $error("access before init");

    property p_release_clears;
        @(posedge CLK) disable iff (SYS_RST)
            (fin && (op_r == sem_host_pkg::OP_RELEASE)) |=> !pending_r && cmd_ready_r;
    endproperty
    a_release_clears: assert property (p_release_clears) else $error("withdraw left pending");

    property p_answer_bound;
        @(posedge CLK) disable iff (SYS_RST)
            (take && legal && (cmd_op != sem_host_pkg::OP_INIT)) |-> ##[4:40] res_valid_r;
    endproperty
    a_answer_bound: assert property (p_answer_bound) else $error("no answer in time");

    property p_refused_holds;
        @(posedge CLK) disable iff (SYS_RST)
            (take && !legal) |=> res_valid_r && res_refused_r && !res_granted_r && cmd_ready_r;
    endproperty
    a_refused_holds: assert property (p_refused_holds) else $error("refusal not reported");

    property p_claim_writes_zero;
        @(posedge CLK) disable iff (SYS_RST)
            (start_r && is_write_r && (op_r == sem_host_pkg::OP_CLAIM))
            |-> (wbit_r == sem_host_pkg::SEM_REQ);
    endproperty
    a_claim_writes_zero: assert property (p_claim_writes_zero) else $error("claim wrote one");

    property p_free_writes_one;
        @(posedge CLK) disable iff (SYS_RST)
            (start_r && ((op_r == sem_host_pkg::OP_INIT) || (op_r == sem_host_pkg::OP_RELEASE)))
            |-> is_write_r && (wbit_r == sem_host_pkg::SEM_FREE);
    endproperty
    a_free_writes_one: assert property (p_free_writes_one) else $error("free wrote zero");

    // A stuck request latch on the device would hang the far side
    property p_pending_marked;
        @(posedge CLK) disable iff (SYS_RST)
            (fin && (op_r == sem_host_pkg::OP_CLAIM) && !granted_nxt)
            |=> pending_r && (pend_idx_r == $past(idx_r));
    endproperty
    a_pending_marked: assert property (p_pending_marked) else $error("failed claim not marked");

    c_granted: cover property (@(posedge CLK) disable iff (SYS_RST)
        fin && (op_r == sem_host_pkg::OP_CLAIM) && granted_nxt);
    c_failed: cover property (@(posedge CLK) disable iff (SYS_RST)
        fin && (op_r == sem_host_pkg::OP_CLAIM) && !granted_nxt);
    c_poll_win: cover property (@(posedge CLK) disable iff (SYS_RST)
        fin && (op_r == sem_host_pkg::OP_POLL) && granted_nxt);
    c_init: cover property (@(posedge CLK) disable iff (SYS_RST) $rose(init_done_r));
endmodule
`default_nettype wire

/* hdl/sem_host_pkg.sv */
// Constants and types for the host that drives one port of a semaphore bank.
// Assumes a single 125 MHz clock and pins sampled synchronously to it.
package sem_host_pkg;
    localparam int DATA_W = 8;
    localparam int SEM_COUNT = 8;
    localparam int IDX_W = 3;
    localparam int CLK_PERIOD_NS = 8;
    localparam int ACCESS_NS = 20;
    localparam int RECOVER_NS = 10;
    // Least times round up, never below one cycle
    localparam int ACCESS_RAW = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_RAW = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC = (ACCESS_RAW < 1) ? 1 : ACCESS_RAW;
    localparam int RECOVER_CYC = (RECOVER_RAW < 1) ? 1 : RECOVER_RAW;
    localparam int CNT_W = 4;
    localparam logic [IDX_W-1:0] IDX_FIRST = 3'h0;
    localparam logic [IDX_W-1:0] IDX_LAST = 3'h7;
    localparam logic SEM_FREE = 1'h1;
    localparam logic SEM_REQ = 1'h0;
    typedef enum logic [1:0] {
        OP_INIT = 2'h0,
        OP_CLAIM = 2'h1,
        OP_POLL = 2'h2,
        OP_RELEASE = 2'h3
    } op_t;
endpackage

/* verif/sem_bank_model.sv */
// Behavioural two-port semaphore bank; the host sits on its left port.
// Assumes both ports are sampled on the host clock; the bench drives the right port.
`timescale 1ns/10ps
`default_nettype none
module sem_bank_model (
    input wire logic clk,
    input wire logic sem_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic rw_n,
    input wire logic [2:0] idx,
    input wire logic [7:0] din,
    input wire logic doe,
    output logic [7:0] dout,
    input wire logic r_sem_n,
    input wire logic r_oe_n,
    input wire logic r_rw_n,
    input wire logic [2:0] r_idx,
    input wire logic [7:0] r_din,
    output logic [7:0] r_dout,
    output logic ce_fault
);
    // Hostile power-up: right owns all eight, both request latches hold zero
    logic [7:0] req_l = 8'h00;
    logic [7:0] req_r = 8'h00;
    logic [7:0] own_l = 8'h00;
    logic [7:0] own_r = 8'hff;
    logic [7:0] rd_l = 8'h00;
    logic [7:0] rd_r = 8'h00;
    logic act_lq = 1'b0;
    logic act_rq = 1'b0;
    wire logic act_l = !sem_n && !oe_n;
    wire logic act_r = !r_sem_n && !r_oe_n;
    initial ce_fault = 1'b0;
    always @(posedge clk) begin
        logic [7:0] rl, rr, ol, orr;
        rl = req_l;
        rr = req_r;
        ol = own_l;
        orr = own_r;
        if (!sem_n && !rw_n && doe) rl[idx] = din[0];
        if (!r_sem_n && !r_rw_n) rr[r_idx] = r_din[0];
        for (int i = 0; i < 8; i++) begin
            if (ol[i] && rl[i]) ol[i] = 1'b0;
            if (orr[i] && rr[i]) orr[i] = 1'b0;
            // Left wins a same-cycle tie; a pending zero takes over at once
            if (!ol[i] && !orr[i] && !rl[i]) ol[i] = 1'b1;
            else if (!ol[i] && !orr[i] && !rr[i]) orr[i] = 1'b1;
        end
        req_l <= rl;
        req_r <= rr;
        own_l <= ol;
        own_r <= orr;
        act_lq <= act_l;
        act_rq <= act_r;
        // Capture on entry only, so the other side cannot tear a read
        if (act_l && !act_lq) rd_l <= {8{!own_l[idx]}};
        if (act_r && !act_rq) rd_r <= {8{!own_r[r_idx]}};
        if (!sem_n && !ce_n) ce_fault <= 1'b1;
    end
    // A released bus shows the inverse of its last value, never a stale copy
    assign dout = act_l ? rd_l : ~rd_l;
    assign r_dout = act_r ? rd_r : ~rd_r;
endmodule
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the semaphore host against a two-port bank model.
// Assumes default access timing; the bench plays the right-hand processor.
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, got) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            error_cnt++; \
            $display("wrong value %s expected %0h seen %0h", name, exp, got); \
        end \
    end
module tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [2:0] cmd_index = 3'h0;
    logic cmd_ready, result_valid, result_granted, result_refused, init_done;
    logic sem_n, ce_n, oe_n, rw_n, doe, ce_fault, g, rf;
    logic [2:0] idx;
    logic [7:0] dout, din, r_dout, rv;
    logic r_sem_n = 1'b1;
    logic r_oe_n = 1'b1;
    logic r_rw_n = 1'b1;
    logic [2:0] r_idx = 3'h0;
    logic [7:0] r_din = 8'h00;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc = 0;
    sem_host dut (.CLK(clk), .SYS_RST(sys_rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_INDEX(cmd_index), .CMD_READY(cmd_ready), .RESULT_VALID(result_valid),
        .RESULT_GRANTED(result_granted), .RESULT_REFUSED(result_refused),
        .INIT_DONE(init_done), .SEMAPHORE_SELECT_N(sem_n), .CHIP_ENABLE_N(ce_n),
        .OUTPUT_ENABLE_N(oe_n), .READ_WRITE_N(rw_n), .SEMAPHORE_INDEX(idx),
        .DATA_OUT(dout), .DATA_OE(doe), .DATA_IN(din));
    sem_bank_model bank (.clk(clk), .sem_n(sem_n), .ce_n(ce_n), .oe_n(oe_n), .rw_n(rw_n),
        .idx(idx), .din(dout), .doe(doe), .dout(din), .r_sem_n(r_sem_n), .r_oe_n(r_oe_n),
        .r_rw_n(r_rw_n), .r_idx(r_idx), .r_din(r_din), .r_dout(r_dout), .ce_fault(ce_fault));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic print_verdict;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // The global cycle ceiling bounds every wait below
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            error_cnt++;
            print_verdict();
        end
    end
    task automatic cmd(input logic [1:0] op, input logic [2:0] ix);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_index <= ix;
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b0;
        do @(posedge clk); while (result_valid !== 1'b1);
        g = result_granted;
        rf = result_refused;
    endtask
    task automatic rport(input logic wr, input logic [2:0] ix, input logic b);
        @(posedge clk);
        r_sem_n <= 1'b0;
        r_oe_n <= wr;
        r_rw_n <= !wr;
        r_idx <= ix;
        r_din <= {8{b}};
        repeat (3) @(posedge clk);
        rv = r_dout;
        r_sem_n <= 1'b1;
        r_oe_n <= 1'b1;
        r_rw_n <= 1'b1;
        r_din <= ~r_din;
        repeat (2) @(posedge clk);
    endtask
    task automatic t_init;
        cmd(2'h1, 3'h1);
        `CHK("early claim refused", 1'b1, rf)
        cmd(2'h0, 3'h0);
        `CHK("init granted", 1'b1, g)
        `CHK("init done", 1'b1, init_done)
        for (int i = 0; i < 8; i++) rport(1'b1, i[2:0], 1'b1);
        // A flag held by the left also reads one here, so claim each to prove it free
        for (int i = 0; i < 8; i++) begin
            rport(1'b0, i[2:0], 1'b1);
            `CHK("free after init", 8'hff, rv)
            rport(1'b1, i[2:0], 1'b0);
            rport(1'b0, i[2:0], 1'b1);
            `CHK("far claim after init", 8'h00, rv)
            rport(1'b1, i[2:0], 1'b1);
        end
    endtask
    task automatic t_handover;
        cmd(2'h1, 3'h7);
        `CHK("claim free", 1'b1, g)
        rport(1'b0, 3'h7, 1'b1);
        `CHK("far side sees one", 8'hff, rv)
        rport(1'b1, 3'h7, 1'b0);
        rport(1'b0, 3'h7, 1'b1);
        `CHK("far request pending", 8'hff, rv)
        cmd(2'h3, 3'h7);
        rport(1'b0, 3'h7, 1'b1);
        `CHK("token passed", 8'h00, rv)
        rport(1'b1, 3'h7, 1'b1);
        rport(1'b0, 3'h7, 1'b1);
        `CHK("freed", 8'hff, rv)
    endtask
    task automatic t_contend;
        rport(1'b1, 3'h3, 1'b0);
        rport(1'b0, 3'h3, 1'b1);
        `CHK("far owns", 8'h00, rv)
        cmd(2'h1, 3'h3);
        `CHK("claim fails", 1'b0, g)
        `CHK("claim ran", 1'b0, rf)
        cmd(2'h1, 3'h4);
        `CHK("other op refused", 1'b1, rf)
        cmd(2'h2, 3'h3);
        `CHK("poll still held", 1'b0, g)
        rport(1'b1, 3'h3, 1'b1);
        cmd(2'h2, 3'h3);
        `CHK("poll after handover", 1'b1, g)
        rport(1'b0, 3'h3, 1'b1);
        `CHK("far sees one", 8'hff, rv)
        cmd(2'h3, 3'h3);
        rport(1'b0, 3'h3, 1'b1);
        `CHK("release frees", 8'hff, rv)
    endtask
    task automatic t_withdraw;
        rport(1'b1, 3'h2, 1'b0);
        cmd(2'h1, 3'h2);
        `CHK("claim fails", 1'b0, g)
        cmd(2'h3, 3'h2);
        `CHK("withdraw", 1'b1, g)
        rport(1'b1, 3'h2, 1'b1);
        rport(1'b0, 3'h2, 1'b1);
        `CHK("no stale request", 8'hff, rv)
        cmd(2'h1, 3'h0);
        `CHK("claim lowest", 1'b1, g)
        cmd(2'h3, 3'h0);
        `CHK("memory never enabled", 1'b0, ce_fault)
    endtask
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        t_init();
        t_handover();
        t_contend();
        t_withdraw();
        print_verdict();
    end
endmodule
`default_nettype wire
